// *** rtl/irq_status_defs.vh ***
// Register addresses, field positions and reset values of the event status block
`ifndef IRQ_STATUS_DEFS_VH
`define IRQ_STATUS_DEFS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_TX_DATA        32'h5000_1310
`define ADDR_MASKED_FLAGS   32'h5000_132C
`define ADDR_ENABLE_MASK    32'h5000_1330
`define ADDR_UNMASKED_FLAGS 32'h5000_1334
`define ADDR_COMBINED_CLR   32'h5000_1340
`define ADDR_ABORT_CLR      32'h5000_1354
`define ADDR_ACTIVITY_CLR   32'h5000_135C
`define ADDR_GENERAL_CALL_FLAG_CLR   32'h5000_1368
`define ADDR_ABORT_CAUSE    32'h5000_1380

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define NUM_SOURCES         12
`define BIT_GENERAL_CALL_FLAG        11
`define BIT_START_SEEN      10
`define BIT_STOP_SEEN       9
`define BIT_ACTIVITY        8
`define BIT_SLAVE_TX_DONE   7
`define BIT_TX_ABORT        6
`define LEVEL_FLAGS_W       6
`define CAUSE_W             16
`define REG_W               16

// ****************************************************************
// Reset values
// ****************************************************************
`define MASK_RESET          12'h8FF
`define FLAGS_RESET         6'h00

`endif

// *** rtl/line_watch.v ***
// Synchroniser and START/STOP condition detector for the two-wire bus lines
`timescale 1ns/1ps

module line_watch
(
	input  wire i_ref_clk,
	input  wire i_rst_b,
	input  wire i_scl,
	input  wire i_sda,
	output reg  o_start_pulse,
	output reg  o_stop_pulse
);

	reg  [2:0] scl_sync_q;
	reg  [2:0] sda_sync_q;
	reg        scl_lvl_q;
	reg        sda_lvl_q;
	wire       scl_agree;
	wire       sda_agree;
	wire       sda_fall;
	wire       sda_rise;

	// ****************************************************************
	// Three-stage capture; only stages two and three are judged
	// ****************************************************************
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[1:0], i_scl};
			sda_sync_q <= {sda_sync_q[1:0], i_sda};
		end
	end

	assign scl_agree = (scl_sync_q[1] == scl_sync_q[2]);
	assign sda_agree = (sda_sync_q[1] == sda_sync_q[2]);

	// Filtered level only moves once two stages agree, which rejects one-cycle glitches
	assign sda_fall = sda_agree && !sda_sync_q[2] && sda_lvl_q;
	assign sda_rise = sda_agree && sda_sync_q[2] && !sda_lvl_q;

	// ****************************************************************
	// Filtered levels and condition pulses
	// ****************************************************************
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			scl_lvl_q     <= 1'b1;
			sda_lvl_q     <= 1'b1;
			o_start_pulse <= 1'b0;
			o_stop_pulse  <= 1'b0;
		end
		else
		begin
			if (scl_agree)
				scl_lvl_q <= scl_sync_q[2];
			if (sda_agree)
				sda_lvl_q <= sda_sync_q[2];
			o_start_pulse <= sda_fall && scl_lvl_q; // Data falls while clock high
			o_stop_pulse  <= sda_rise && scl_lvl_q; // Data rises while clock high
		end
	end

endmodule

// *** rtl/event_status.v ***
// Interrupt mask, raw and masked event flags of the two-wire bus controller
`timescale 1ns/1ps
`include "irq_status_defs.vh"

module event_status
(
	input  wire                      i_ref_clk,
	input  wire                      i_rst_b,
	input  wire                      i_ctrl_enable,
	input  wire [31:0]               i_reg_addr,
	input  wire                      i_reg_wr,
	input  wire                      i_reg_rd,
	input  wire [15:0]               i_reg_wdata,
	output reg  [15:0]               o_reg_rdata,
	input  wire                      i_scl,
	input  wire                      i_sda,
	input  wire                      i_general_call_flag_ack,
	input  wire                      i_slave_tx_nack,
	input  wire                      i_tx_abort,
	input  wire [`CAUSE_W-1:0]       i_abort_cause,
	input  wire                      i_busy,
	input  wire [`LEVEL_FLAGS_W-1:0] i_level_flags,
	input  wire                      i_rx_byte_valid,
	input  wire [7:0]                i_rx_byte,
	output reg                       o_rx_push,
	output reg  [7:0]                o_rx_data,
	output reg                       o_tx_push,
	output reg  [7:0]                o_tx_data,
	output reg                       o_tx_flush,
	output reg                       o_irq
);

	reg  [`NUM_SOURCES-1:0] mask_q;
	reg                     general_call_flag_q;
	reg                     start_q;
	reg                     stop_q;
	reg                     activity_q;
	reg                     tx_done_q;
	reg                     abort_q;
	reg  [`CAUSE_W-1:0]     cause_q;
	wire                    start_pulse;
	wire                    stop_pulse;
	wire [`NUM_SOURCES-1:0] raw_flags;
	wire [`NUM_SOURCES-1:0] masked_flags;
	wire                    rd_general_call_flag_clr;
	wire                    rd_activity_clr;
	wire                    rd_combined_clr;
	wire                    rd_abort_clr;

	// Single address decode used by every read-to-clear and write strobe
	function hit;
		input [31:0] addr;
		input [31:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// ****************************************************************
	// Bus line watcher
	// ****************************************************************
	line_watch u_line_watch
	(
		.i_ref_clk     (i_ref_clk),
		.i_rst_b       (i_rst_b),
		.i_scl         (i_scl),
		.i_sda         (i_sda),
		.o_start_pulse (start_pulse),
		.o_stop_pulse  (stop_pulse)
	);

	// ****************************************************************
	// Read-to-clear strobes
	// ****************************************************************
	assign rd_general_call_flag_clr = i_reg_rd && hit(i_reg_addr, `ADDR_GENERAL_CALL_FLAG_CLR);
	assign rd_activity_clr = i_reg_rd && hit(i_reg_addr, `ADDR_ACTIVITY_CLR);
	assign rd_combined_clr = i_reg_rd && hit(i_reg_addr, `ADDR_COMBINED_CLR);
	assign rd_abort_clr    = i_reg_rd && hit(i_reg_addr, `ADDR_ABORT_CLR);

	// Raw and masked views; FIFO level bits are tracked by the FIFO block
	assign raw_flags    = {general_call_flag_q, start_q, stop_q, activity_q, tx_done_q, abort_q,
	                       i_level_flags};
	assign masked_flags = raw_flags & mask_q;

	// ****************************************************************
	// Mask register
	// ****************************************************************
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			mask_q <= `MASK_RESET;
		else if (i_reg_wr && hit(i_reg_addr, `ADDR_ENABLE_MASK))
			mask_q <= i_reg_wdata[`NUM_SOURCES-1:0];
	end

	// ****************************************************************
	// Sticky event flags; a set in the clear cycle wins
	// ****************************************************************
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			general_call_flag_q <= 1'b0;
			start_q    <= 1'b0;
			stop_q     <= 1'b0;
			activity_q <= 1'b0;
			tx_done_q  <= 1'b0;
			abort_q    <= 1'b0;
		end
		else if (!i_ctrl_enable)
		begin
			// Disabling drops every sticky flag and ignores bus events
			general_call_flag_q <= 1'b0;
			start_q    <= 1'b0;
			stop_q     <= 1'b0;
			activity_q <= 1'b0;
			tx_done_q  <= 1'b0;
			abort_q    <= 1'b0;
		end
		else
		begin
			if (i_general_call_flag_ack)
				general_call_flag_q <= 1'b1;
			else if (rd_general_call_flag_clr || rd_combined_clr)
				general_call_flag_q <= 1'b0;

			if (start_pulse)
				start_q <= 1'b1;
			else if (rd_combined_clr)
				start_q <= 1'b0;

			if (stop_pulse)
				stop_q <= 1'b1;
			else if (rd_combined_clr)
				stop_q <= 1'b0;

			// Activity is sticky: idle alone never clears it
			if (i_busy || start_pulse)
				activity_q <= 1'b1;
			else if (rd_activity_clr || rd_combined_clr)
				activity_q <= 1'b0;

			if (i_slave_tx_nack)
				tx_done_q <= 1'b1;
			else if (rd_combined_clr)
				tx_done_q <= 1'b0;

			if (i_tx_abort)
				abort_q <= 1'b1;
			else if (rd_abort_clr || rd_combined_clr)
				abort_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Abort cause capture
	// ****************************************************************
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			cause_q <= {`CAUSE_W{1'b0}};
		else if (i_tx_abort)
			cause_q <= i_abort_cause;
		else if (rd_abort_clr || rd_combined_clr)
			cause_q <= {`CAUSE_W{1'b0}};
	end

	// ****************************************************************
	// Read data mux, registered; unmapped addresses read zero
	// ****************************************************************
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_reg_rdata <= 16'h0000;
		else if (i_reg_rd)
		begin
			if (hit(i_reg_addr, `ADDR_ENABLE_MASK))
				o_reg_rdata <= {4'h0, mask_q};
			else if (hit(i_reg_addr, `ADDR_UNMASKED_FLAGS))
				o_reg_rdata <= {4'h0, raw_flags};
			else if (hit(i_reg_addr, `ADDR_MASKED_FLAGS))
				o_reg_rdata <= {4'h0, masked_flags};
			else if (hit(i_reg_addr, `ADDR_ABORT_CAUSE))
				o_reg_rdata <= cause_q;
			else if (rd_general_call_flag_clr)
				o_reg_rdata <= {15'h0000, general_call_flag_q};
			else if (rd_activity_clr)
				o_reg_rdata <= {15'h0000, activity_q};
			else if (rd_abort_clr)
				o_reg_rdata <= {15'h0000, abort_q};
			else if (rd_combined_clr)
				o_reg_rdata <= {15'h0000, |masked_flags};
			else
				o_reg_rdata <= 16'h0000;
		end
	end

	// ****************************************************************
	// Receive and transmit data paths, interrupt output
	// ****************************************************************
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_rx_push  <= 1'b0;
			o_rx_data  <= 8'h00;
			o_tx_push  <= 1'b0;
			o_tx_data  <= 8'h00;
			o_tx_flush <= 1'b0;
			o_irq      <= 1'b0;
		end
		else
		begin
			// General-call payload is not filtered; it lands like any byte
			o_rx_push  <= i_rx_byte_valid && i_ctrl_enable;
			o_rx_data  <= i_rx_byte;
			// Writes during an abort are dropped so the FIFO stays empty
			o_tx_push  <= i_reg_wr && hit(i_reg_addr, `ADDR_TX_DATA) && !abort_q
			              && !i_tx_abort;
			o_tx_data  <= i_reg_wdata[7:0];
			// Follows the abort flag's next value, so flush and flag end on one edge
			o_tx_flush <= i_ctrl_enable && (i_tx_abort || (abort_q && !rd_abort_clr
			              && !rd_combined_clr));
			o_irq      <= |masked_flags;
		end
	end

endmodule

// *** bench/link_master.sv ***
// Remote bus master model driving START and STOP on the two wires
`timescale 1ns/1ps
// ********
// Remote master
// ********
module link_master
(
	output logic o_scl,
	output logic o_sda
);
	// Pull-ups hold both lines high; the clock stands still between frames
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Data falls while the clock is high; a call with the clock low is a restart
	task start_cond;
	begin
		// Data only moves a while after the clock fell, never on the same instant
		#100 o_sda = 1'b1;
		#100 o_scl = 1'b1;
		#100 o_sda = 1'b0;
		#100 o_scl = 1'b0;
	end
	endtask
	// Data rises while the clock is high, then the lines are released
	task stop_cond;
	begin
		#100 o_sda = 1'b0;
		#100 o_scl = 1'b1;
		#100 o_sda = 1'b1;
		#100;
	end
	endtask
endmodule

// *** bench/event_status_props.sv ***
// Port-level checker for the event status block
`timescale 1ns/1ps
`include "irq_status_defs.vh"
// ********
// Checker
// ********
module event_status_props
(
	input wire        i_ref_clk,
	input wire        i_rst_b,
	input wire        i_ctrl_enable,
	input wire [31:0] i_reg_addr,
	input wire        i_reg_wr,
	input wire        i_reg_rd,
	input wire [15:0] i_reg_wdata,
	input wire        i_scl,
	input wire        i_sda,
	input wire        i_general_call_flag_ack,
	input wire        i_slave_tx_nack,
	input wire        i_tx_abort,
	input wire        i_busy,
	input wire [5:0]  i_level_flags,
	input wire        i_rx_byte_valid,
	input wire [7:0]  i_rx_byte,
	input wire        o_rx_push,
	input wire [7:0]  o_rx_data,
	input wire        o_tx_push,
	input wire [7:0]  o_tx_data,
	input wire        o_tx_flush,
	input wire        o_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// Decoded register strokes
	wire tx_wr = i_reg_wr && i_reg_addr == `ADDR_TX_DATA;
	wire ab_rd = i_reg_rd && i_reg_addr == `ADDR_ABORT_CLR;
	wire cc_rd = i_reg_rd && i_reg_addr == `ADDR_COMBINED_CLR;
	// Idle pins for eight cycles, so no detector pulse is still in flight
	wire quiet = !(i_general_call_flag_ack | i_slave_tx_nack | i_tx_abort | i_busy)
		&& i_level_flags == 6'h00 && i_scl && i_sda;
	sequence clear_read;
		quiet[*8] ##0 cc_rd ##1 quiet;
	endsequence
	sequence off_idle;
		(!i_ctrl_enable && i_level_flags == 6'h00)[*2];
	endsequence
	AST_RX_PUSH: assert property (i_rx_byte_valid && i_ctrl_enable |=>
		o_rx_push && o_rx_data == $past(i_rx_byte)) else $error("rx byte lost");
	AST_FLUSH_SET: assert property (i_tx_abort && i_ctrl_enable |=> o_tx_flush)
		else $error("no flush on abort");
	AST_FLUSH_HOLD: assert property (o_tx_flush && i_ctrl_enable && !ab_rd && !cc_rd
		|=> o_tx_flush) else $error("flush dropped early");
	AST_FLUSH_END: assert property (ab_rd && !i_tx_abort |=> !o_tx_flush)
		else $error("flush not released");
	AST_TX_DROP: assert property (tx_wr && o_tx_flush |=> !o_tx_push)
		else $error("tx write during flush");
	AST_TX_PUSH: assert property (tx_wr && !o_tx_flush && !i_tx_abort && i_ctrl_enable
		|=> o_tx_push && o_tx_data == $past(i_reg_wdata[7:0])) else $error("tx write lost");
	AST_CLR_IRQ: assert property (clear_read |=> !o_irq) else $error("irq after clear");
	AST_OFF_IRQ: assert property (off_idle |=> !o_irq) else $error("irq while off");
endmodule
bind event_status event_status_props u_props (.*);

// *** bench/event_status_tb.sv ***
// Self-checking bench for the event status block
`timescale 1ns/1ps
`include "irq_status_defs.vh"
// ********
// Bench top
// ********
module event_status_tb;
	logic        i_ref_clk, i_rst_b, i_ctrl_enable, i_reg_wr, i_reg_rd, i_busy;
	logic        i_general_call_flag_ack, i_slave_tx_nack, i_tx_abort, i_rx_byte_valid;
	logic [31:0] i_reg_addr;
	logic [15:0] i_reg_wdata, i_abort_cause, o_reg_rdata;
	logic [5:0]  i_level_flags;
	logic [7:0]  i_rx_byte, o_rx_data, o_tx_data;
	logic        o_rx_push, o_tx_push, o_tx_flush, o_irq;
	wire         i_scl, i_sda;
	int          fail_count = 0, samples_checked = 0, msk = 'h8FF, fl = 0, w;
	int          exp_q[$];
	// Design and remote master
	event_status u_dut (.*);
	link_master  u_link (.o_scl(i_scl), .o_sda(i_sda));
	// Model raw view: sticky flags over live level flags
	function logic [15:0] raw_m();
		raw_m = 16'(fl | i_level_flags);
	endfunction
	task chk(input logic [15:0] got, input int exp);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// Read strobe for one cycle; data is settled one edge later
	task chkrd(input logic [31:0] a, input int exp);
	begin
		@(posedge i_ref_clk) #1;
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		@(posedge i_ref_clk) #1;
		i_reg_rd = 1'b0;
		chk(o_reg_rdata, exp);
	end
	endtask
	task wr(input logic [31:0] a, input logic [15:0] d);
	begin
		@(posedge i_ref_clk) #1;
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(posedge i_ref_clk) #1;
		i_reg_wr = 1'b0;
	end
	endtask
	// One-cycle event pulse: 0 general_call_flag, 1 nack, 2 abort, 3 busy, 4 rx byte
	task pulse(input int k);
	begin
		@(posedge i_ref_clk) #1;
		{i_general_call_flag_ack, i_slave_tx_nack, i_tx_abort, i_busy, i_rx_byte_valid} = 5'h10 >> k;
		@(posedge i_ref_clk) #1;
		{i_general_call_flag_ack, i_slave_tx_nack, i_tx_abort, i_busy, i_rx_byte_valid} = 5'h00;
	end
	endtask
	task end_sim;
	begin
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	// Reference clock
	initial
	begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end
	// Watchdog, far beyond the expected few hundred cycles
	initial
	begin
		#500000;
		fail_count++;
		end_sim;
	end
	// Main sequence
	initial
	begin
		void'($urandom(78560));
		{i_reg_wr, i_reg_rd, i_general_call_flag_ack, i_slave_tx_nack, i_tx_abort} = 5'h00;
		{i_busy, i_rx_byte_valid, i_rst_b, i_ctrl_enable} = 4'h1;
		i_reg_addr = 32'h0000_0000;
		i_reg_wdata = 16'h0000;
		i_abort_cause = 16'($urandom);
		i_level_flags = 6'($urandom);
		i_rx_byte = 8'($urandom);
		repeat (16) @(posedge i_ref_clk);
		#1 i_rst_b = 1'b1;
		chkrd(`ADDR_ENABLE_MASK, msk);
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		w = $urandom;
		wr(`ADDR_ENABLE_MASK, 16'(w));
		msk = w & 'hFFF;
		chkrd(`ADDR_ENABLE_MASK, msk);
		pulse(0);
		fl = fl | 'h800;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		chkrd(`ADDR_GENERAL_CALL_FLAG_CLR, 1);
		fl = fl & ~'h800;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		pulse(4);
		chk(o_rx_push, 1);
		chk(o_rx_data, i_rx_byte);
		u_link.start_cond;
		u_link.start_cond;
		u_link.stop_cond;
		repeat (10) @(posedge i_ref_clk);
		fl = fl | 'h700;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		chkrd(`ADDR_ACTIVITY_CLR, 1);
		fl = fl & ~'h100;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		pulse(1);
		pulse(3);
		fl = fl | 'h180;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		pulse(2);
		fl = fl | 'h40;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		chkrd(`ADDR_ABORT_CAUSE, i_abort_cause);
		wr(`ADDR_TX_DATA, 16'h00A5);
		chk(o_tx_push, 0);
		chk(o_tx_flush, 1);
		chkrd(`ADDR_ABORT_CLR, 1);
		fl = fl & ~'h40;
		w = $urandom;
		exp_q.push_back(w & 'hFF);
		wr(`ADDR_TX_DATA, 16'(w));
		chk(o_tx_push, 1);
		chk(o_tx_data, exp_q.pop_front());
		// Walk a single enabled source across all twelve mask bits
		for (int i = 0; i < 12; i++)
		begin
			msk = 1 << i;
			wr(`ADDR_ENABLE_MASK, 16'(msk));
			chkrd(`ADDR_MASKED_FLAGS, raw_m() & msk);
			chk(o_irq, (raw_m() & msk) != 0);
		end
		i_level_flags = 6'h00;
		wr(`ADDR_ENABLE_MASK, 16'h0FFF);
		repeat (8) @(posedge i_ref_clk);
		chkrd(`ADDR_COMBINED_CLR, 1);
		fl = 0;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		pulse(0);
		fl = 'h800;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		@(posedge i_ref_clk) #1;
		i_ctrl_enable = 1'b0;
		fl = 0;
		pulse(4);
		chk(o_rx_push, 0);
		i_ctrl_enable = 1'b1;
		chkrd(`ADDR_UNMASKED_FLAGS, raw_m());
		end_sim;
	end
endmodule
